// [dv/eclw_eeprom_model.sv]
// Behavioural EEPROM image answering the loader's word fetch port
`timescale 1ns/1ps
module eclw_eeprom_model (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Fetch port
    input wire eep_req,
    input wire [7:0] eep_addr,
    output reg eep_ack,
    output reg [15:0] eep_data,
    // Image {0Eh,0Ch,0Ah,08h} and slow answer mode
    input wire [63:0] image,
    input wire slow
);
    reg [2:0] dly;
    // One ack per request; data scrambles whenever it is not valid
    always @(posedge clk_sys) begin
        eep_ack <= 1'h0;
        eep_data <= ~eep_data;
        if (rst) begin
            dly <= 3'h0;
            eep_data <= 16'h5A5A;
        end else if (eep_req && !eep_ack && dly < {slow, 2'h0}) begin
            dly <= dly + 3'h1;
        end else if (eep_req && !eep_ack) begin
            dly <= 3'h0;
            eep_ack <= 1'h1;
            eep_data <= image[eep_addr[2:1]*16 +: 16];
        end
    end
endmodule

// [dv/eclw_loader_checker.sv]
// Assertion checker for the EEPROM capability word loader
`timescale 1ns/1ps
module eclw_loader_checker #(
    parameter NPORTS = 3
) (
    // Clock, reset, fetch port
    input wire clk_sys,
    input wire rst,
    input wire eep_req,
    input wire [7:0] eep_addr,
    input wire eep_ack,
    input wire [15:0] eep_data,
    // Bus readies
    input wire s_axil_awready,
    input wire s_axil_wready,
    input wire s_axil_arready,
    // Images
    input wire [15:0] subsys_vendor_id,
    input wire [15:0] subsys_id,
    input wire [NPORTS*32-1:0] port_devcap,
    input wire [NPORTS*32-1:0] port_linkcap,
    input wire [NPORTS*32-1:0] port_capdis,
    input wire [NPORTS*32-1:0] port_phyctl,
    input wire [NPORTS*32-1:0] port_tlctl,
    input wire [NPORTS*32-1:0] port_txmgn,
    input wire [NPORTS*32-1:0] port_devcap2,
    input wire load_done
);
    reg [15:0] cw, mw, vid, sid;
    // Words seen on the fetch port; reset restores built-in values
    always @(posedge clk_sys) begin
        if (rst) begin
            cw <= 16'h001D;
            mw <= 16'h916B;
            vid <= 16'h0000;
            sid <= 16'h0000;
        end else if (eep_req && eep_ack) begin
            case (eep_addr)
                8'h08: vid <= eep_data;
                8'h0A: sid <= eep_data;
                8'h0C: cw <= eep_data;
                default: mw <= eep_data;
            endcase
        end
    end
    // Expected image of one port; unfed bits must read 0
    wire [31:0] e_dc = {16'h0, cw[4], 13'h0, cw[1:0]};
    wire [31:0] e_lc = {10'h0, cw[9], 1'h0, cw[12], 7'h0, cw[3:2], 10'h0};
    wire [31:0] e_cd = {17'h0, cw[5], cw[7], 13'h0};
    wire [31:0] e_pc = {16'h0, cw[6], 15'h0};
    wire [31:0] e_tl = {25'h0, cw[10], cw[8], 1'h0, cw[15], 1'h0, cw[13], cw[11]};
    wire [31:0] e_mg = {17'h0, mw[14:0]};
    wire [31:0] e_d2 = {13'h0, mw[15], 5'h0, cw[14], 12'h0};

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // A fetch answered, then one idle cycle and the next word
    sequence s_ack;
        eep_req && eep_ack;
    endsequence
    sequence s_gap_next;
        !eep_req ##1 eep_req && eep_addr == $past(eep_addr, 2) + 8'h02;
    endsequence

    AST_DEVCAP: assert property (load_done |-> port_devcap == {NPORTS{e_dc}})
        else $error("devcap image wrong");
    AST_LINKCAP: assert property (load_done |-> port_linkcap == {NPORTS{e_lc}})
        else $error("linkcap image wrong");
    AST_CAPDIS: assert property (load_done |-> port_capdis == {NPORTS{e_cd}})
        else $error("capdis image wrong");
    AST_PHYCTL: assert property (load_done |-> port_phyctl == {NPORTS{e_pc}})
        else $error("phyctl image wrong");
    AST_TLCTL: assert property (load_done |-> port_tlctl == {NPORTS{e_tl}})
        else $error("tlctl image wrong");
    AST_TXMGN: assert property (load_done |-> port_txmgn == {NPORTS{e_mg}})
        else $error("margin image wrong");
    AST_DEVCAP2: assert property (load_done |-> port_devcap2 == {NPORTS{e_d2}})
        else $error("devcap2 image wrong");
    AST_SUBSYS: assert property (load_done |-> {subsys_id, subsys_vendor_id} == {sid, vid})
        else $error("subsystem words wrong");
    AST_NO_EARLY: assert property (!load_done |-> !(s_axil_awready || s_axil_wready || s_axil_arready))
        else $error("bus taken before load done");
    AST_FETCH_ORDER: assert property (s_ack ##0 eep_addr != 8'h0E |=> s_gap_next)
        else $error("fetch order wrong");
    AST_LOAD_DONE: assert property (s_ack ##0 eep_addr == 8'h0E |-> ##[2:3] $rose(load_done))
        else $error("load done late");
endmodule

// [dv/test_eeprom_capability_word_loader.sv]
// Self-checking bench for the EEPROM capability word loader
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    comparisons = comparisons + 1; \
    if ((g) !== (e)) begin \
        error_cnt = error_cnt + 1; \
        $display("BAD %s exp %h got %h", n, e, g); \
    end \
end
module test_eeprom_capability_word_loader;
    reg clk_sys = 1'h0;
    reg rst = 1'h1;
    reg eep_absent = 1'h0;
    reg slow = 1'h0;
    reg [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
    reg [31:0] s_axil_wdata = 32'h0;
    reg [3:0] s_axil_wstrb = 4'hF;
    reg s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
    reg s_axil_arvalid = 1'h0, s_axil_rready = 1'h0;
    wire eep_req, eep_ack, s_axil_awready, s_axil_wready, s_axil_bvalid;
    wire s_axil_arready, s_axil_rvalid, load_done;
    wire [7:0] eep_addr;
    wire [15:0] eep_data, subsys_vendor_id, subsys_id;
    wire [1:0] s_axil_bresp, s_axil_rresp;
    wire [31:0] s_axil_rdata;
    wire [95:0] port_devcap, port_linkcap, port_capdis, port_phyctl;
    wire [95:0] port_tlctl, port_txmgn, port_devcap2;
    integer error_cnt = 0, comparisons = 0, seed = 32'h9E58;
    integer cw, mw, vid, sid, it, p;
    reg [31:0] rd;
    reg [1:0] rs;
    wire [63:0] image = {mw[15:0], cw[15:0], sid[15:0], vid[15:0]};

    eclw_loader eclw_loader_i (.*);
    eclw_eeprom_model eclw_eeprom_model_i (.*);

    initial forever #4 clk_sys = ~clk_sys;

    function integer b(input integer v, input integer i);
        b = (v >> i) & 1;
    endfunction
    // Bench model of the subsystem, word and port image readbacks; port 3 selects nothing
    function [31:0] m(input [7:0] o);
        begin
            case (o)
                8'h08: m = sid << 16 | vid;
                8'h0C: m = mw << 16 | cw;
                8'h20: m = b(cw, 4) << 15 | (cw & 3);
                8'h24: m = b(cw, 2) << 10 | b(cw, 3) << 11 | b(cw, 12) << 19
                    | b(cw, 9) << 21;
                8'h28: m = b(cw, 5) << 14 | b(cw, 7) << 13;
                8'h2C: m = b(cw, 6) << 15;
                8'h30: m = b(cw, 11) | b(cw, 13) << 1 | b(cw, 15) << 3
                    | b(cw, 8) << 5 | b(cw, 10) << 6;
                8'h34: m = mw & 32'h7FFF;
                default: m = b(cw, 14) << 12 | b(mw, 15) << 18;
            endcase
            if (p == 3 && o > 8'h1F)
                m = 0;
        end
    endfunction

    task complete_run;
        begin
            $display("mismatches %0d of %0d", error_cnt, comparisons);
            if (error_cnt == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // Write (w=1) or read; each valid dropped after its ready edge
    task ax(input w, input [7:0] a, input [31:0] wd, output [31:0] d,
        output [1:0] r);
        integer n;
        reg ah, wh, rh, dn;
        begin
            @(posedge clk_sys);
            s_axil_awaddr <= a;
            s_axil_araddr <= a;
            s_axil_wdata <= wd;
            s_axil_awvalid <= w;
            s_axil_wvalid <= w;
            s_axil_bready <= w;
            s_axil_arvalid <= !w;
            s_axil_rready <= !w;
            dn = 0;
            for (n = 0; n < 4000 && !dn; n = n + 1) begin
                @(negedge clk_sys);
                ah = s_axil_awready;
                wh = s_axil_wready;
                rh = s_axil_arready;
                dn = w ? s_axil_bvalid : s_axil_rvalid;
                d = s_axil_rdata;
                r = w ? s_axil_bresp : s_axil_rresp;
                @(posedge clk_sys);
                if (ah) s_axil_awvalid <= 1'h0;
                if (wh) s_axil_wvalid <= 1'h0;
                if (rh) s_axil_arvalid <= 1'h0;
            end
            s_axil_bready <= 1'h0;
            s_axil_rready <= 1'h0;
            if (!dn) begin
                error_cnt = error_cnt + 1;
                $display("BAD wait exp answer got timeout");
                complete_run;
            end
        end
    endtask
    task chk(input [7:0] a, input [31:0] e);
        begin
            ax(1'h0, a, 0, rd, rs);
            `CHK("rresp", 2'h0, rs)
            `CHK("rdata", e, rd)
        end
    endtask
    // Every port image, the words, and the done flag
    task verify;
        begin
            for (p = 0; p < 4; p = p + 1) begin
                ax(1'h1, 8'h10, p, rd, rs);
                `CHK("sel", 2'h0, rs)
                chk(8'h20, m(8'h20));
                chk(8'h24, m(8'h24));
                chk(8'h28, m(8'h28));
                chk(8'h2C, m(8'h2C));
                chk(8'h30, m(8'h30));
                chk(8'h34, m(8'h34));
                chk(8'h38, m(8'h38));
            end
            chk(8'h08, m(8'h08));
            chk(8'h0C, m(8'h0C));
            `CHK("vid", vid[15:0], subsys_vendor_id)
            ax(1'h0, 8'h04, 0, rd, rs);
            `CHK("done", 1'h1, rd[0])
        end
    endtask

    initial begin
        cw = $random(seed) & 32'hFFFF;
        mw = $random(seed) & 32'hFFFF;
        vid = $random(seed) & 32'hFFFF;
        sid = $random(seed) & 32'hFFFF;
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        verify;
        // Unmapped read and a write to a read-only place are refused
        ax(1'h0, 8'h40, 0, rd, rs);
        `CHK("unmapped", 34'h200000000, {rs, rd})
        ax(1'h1, 8'h04, 32'hFFFFFFFF, rd, rs);
        `CHK("ro write", 2'h2, rs)
        // Reloads with new images, fast and slow EEPROM, control and margin words all ones first
        for (it = 1; it < 4; it = it + 1) begin
            cw = it == 1 ? 32'hFFFF : $random(seed) & 32'hFFFF;
            mw = it == 1 ? 32'hFFFF : $random(seed) & 32'hFFFF;
            vid = $random(seed) & 32'hFFFF;
            sid = $random(seed) & 32'hFFFF;
            slow <= it[0];
            ax(1'h1, 8'h00, 32'h1, rd, rs);
            `CHK("reload", 2'h0, rs)
            verify;
        end
        // Reset mid-run with no image: built-in values apply
        eep_absent <= 1'h1;
        rst <= 1'h1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        cw = 32'h001D;
        mw = 32'h916B;
        vid = 0;
        sid = 0;
        verify;
        complete_run;
    end
endmodule

bind eclw_loader eclw_loader_checker #(.NPORTS(NPORTS)) eclw_loader_checker_i (.*);

// [rtl/eclw_axil_slave.v]
// AXI4-Lite slave front end for the loader registers
`timescale 1ns/1ps
`include "eclw_defines.vh"

module eclw_axil_slave (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Gate: no access is taken while low
    input wire accept,
    // AXI4-Lite write channels
    input wire [7:0] s_axil_awaddr,
    input wire s_axil_awvalid,
    output wire s_axil_awready,
    input wire [31:0] s_axil_wdata,
    input wire [3:0] s_axil_wstrb,
    input wire s_axil_wvalid,
    output wire s_axil_wready,
    output reg [1:0] s_axil_bresp,
    output reg s_axil_bvalid,
    input wire s_axil_bready,
    // AXI4-Lite read channels
    input wire [7:0] s_axil_araddr,
    input wire s_axil_arvalid,
    output wire s_axil_arready,
    output reg [31:0] s_axil_rdata,
    output reg [1:0] s_axil_rresp,
    output reg s_axil_rvalid,
    input wire s_axil_rready,
    // Register file side
    output wire wr_en,
    output reg [7:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    input wire wr_err,
    output wire rd_en,
    output wire [7:0] rd_addr,
    input wire [31:0] rd_data,
    input wire rd_err
);

    reg aw_held;
    reg w_held;

    // Address and data are held separately so either may come first
    assign s_axil_awready = accept && !aw_held && !s_axil_bvalid;
    assign s_axil_wready = accept && !w_held && !s_axil_bvalid;
    assign wr_en = aw_held && w_held && !s_axil_bvalid;
    assign s_axil_arready = accept && !s_axil_rvalid;
    assign rd_en = s_axil_arvalid && s_axil_arready;
    assign rd_addr = s_axil_araddr;

    // Write path: capture, perform, respond
    always @(posedge clk_sys) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= `ECLW_RESP_OKAY;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axil_awaddr;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_held <= 1'b1;
                wr_data <= s_axil_wdata;
                wr_strb <= s_axil_wstrb;
            end
            if (wr_en) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axil_bvalid <= 1'b1;
                s_axil_bresp <= wr_err ? `ECLW_RESP_SLVERR : `ECLW_RESP_OKAY;
            end else if (s_axil_bvalid && s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    // Read path: data is sampled at the address handshake
    always @(posedge clk_sys) begin
        if (rst) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h00000000;
            s_axil_rresp <= `ECLW_RESP_OKAY;
        end else if (rd_en) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rdata <= rd_err ? 32'h00000000 : rd_data;
            s_axil_rresp <= rd_err ? `ECLW_RESP_SLVERR : `ECLW_RESP_OKAY;
        end else if (s_axil_rvalid && s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end

endmodule

// [rtl/eclw_defines.vh]
// Constants for the EEPROM capability word loader
`ifndef ECLW_DEFINES_VH
`define ECLW_DEFINES_VH

// EEPROM word addresses (byte addressed image)
`define ECLW_EEP_SUBSYS_VID 8'h08
`define ECLW_EEP_SUBSYS_ID 8'h0A
`define ECLW_EEP_CAP_CTRL 8'h0C
`define ECLW_EEP_TX_MARGIN 8'h0E

// Built-in word values used when nothing is loaded
`define ECLW_DEF_SUBSYS_VID 16'h0000
`define ECLW_DEF_SUBSYS_ID 16'h0000
`define ECLW_DEF_CAP_CTRL 16'h001D
`define ECLW_DEF_TX_MARGIN 16'h916B

// Bit positions in the capability control word and the margin word
`define ECLW_CW_MPS 0
`define ECLW_CW_ASPM 2
`define ECLW_CW_RBER 4
`define ECLW_CW_MSI_DIS 5
`define ECLW_CW_CPAR_DIS 6
`define ECLW_CW_PM_DIS 7
`define ECLW_CW_ORD5 8
`define ECLW_CW_LBN 9
`define ECLW_CW_FREEZE 10
`define ECLW_CW_SOF 11
`define ECLW_CW_SDOWN 12
`define ECLW_CW_PMDS 13
`define ECLW_CW_LTR 14
`define ECLW_CW_4KB 15
`define ECLW_MW_OBFF 15

// Bit positions in the configuration fields
`define ECLW_F_MPS 0
`define ECLW_F_RBER 15
`define ECLW_F_ASPM 10
`define ECLW_F_SDOWN 19
`define ECLW_F_LBN 21
`define ECLW_F_PM_DIS 13
`define ECLW_F_MSI_DIS 14
`define ECLW_F_CPAR_DIS 15
`define ECLW_F_SOF 0
`define ECLW_F_PMDS 1
`define ECLW_F_4KB 3
`define ECLW_F_ORD5 5
`define ECLW_F_FREEZE 6
`define ECLW_F_MGN_LOW 0
`define ECLW_F_MGN_HIGH 5
`define ECLW_F_MGN_HALF 10
`define ECLW_F_LTR 12
`define ECLW_F_OBFF 18

// AXI4-Lite register byte offsets
`define ECLW_REG_CTRL 8'h00
`define ECLW_REG_STATUS 8'h04
`define ECLW_REG_SUBSYS 8'h08
`define ECLW_REG_WORDS 8'h0C
`define ECLW_REG_PORT_SEL 8'h10
`define ECLW_REG_DEVCAP 8'h20
`define ECLW_REG_LINKCAP 8'h24
`define ECLW_REG_CAPDIS 8'h28
`define ECLW_REG_PHYCTL 8'h2C
`define ECLW_REG_TLCTL 8'h30
`define ECLW_REG_TXMGN 8'h34
`define ECLW_REG_DEVCAP2 8'h38

// Bus responses
`define ECLW_RESP_OKAY 2'h0
`define ECLW_RESP_SLVERR 2'h2

`endif

// [rtl/eclw_loader.v]
// EEPROM capability word loader: fetches words 08h-0Eh, drives port fields
`timescale 1ns/1ps
`include "eclw_defines.vh"

// How it works
// - Control word bits 1:0 to C4h[1:0]
// - Control word bits 3:2 to CCh[11:10]
// - Control word bit 4 to C4h[15]
// - Control word bit 5 disables MSI, 70h[14]
// - Control word bit 6 to 74h[15]
// - Control word bit 7 disables PM, 70h[13]
// - Control word bit 8 to 8Ch[5]
// - Control word bit 9 to CCh[21], named ports
// - Control word bit 10 freezes ordering, 8Ch[6]
// - Control word bit 11 to 8Ch[0]
// - Control word bit 12 to CCh[19]
// - Control word bit 13 to 8Ch[1]
// - Control word bit 14 to E4h[12]
// - Control word bit 15 to 8Ch[3]
// - Word 0Eh margins to 94h[14:0]
// - Word 0Eh bit 15 to E4h[18]
module eclw_loader #(
    parameter NPORTS = 3,
    parameter [NPORTS-1:0] LBN_PORT_MASK = 3'b111
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // EEPROM word fetch port (same clock domain)
    output reg eep_req,
    output reg [7:0] eep_addr,
    input wire eep_ack,
    input wire [15:0] eep_data,
    input wire eep_absent,
    // AXI4-Lite register bus
    input wire [7:0] s_axil_awaddr,
    input wire s_axil_awvalid,
    output wire s_axil_awready,
    input wire [31:0] s_axil_wdata,
    input wire [3:0] s_axil_wstrb,
    input wire s_axil_wvalid,
    output wire s_axil_wready,
    output wire [1:0] s_axil_bresp,
    output wire s_axil_bvalid,
    input wire s_axil_bready,
    input wire [7:0] s_axil_araddr,
    input wire s_axil_arvalid,
    output wire s_axil_arready,
    output wire [31:0] s_axil_rdata,
    output wire [1:0] s_axil_rresp,
    output wire s_axil_rvalid,
    input wire s_axil_rready,
    // Loaded configuration images, port 0 in the low word
    output reg [15:0] subsys_vendor_id,
    output reg [15:0] subsys_id,
    output reg [NPORTS*32-1:0] port_devcap,
    output reg [NPORTS*32-1:0] port_linkcap,
    output reg [NPORTS*32-1:0] port_capdis,
    output reg [NPORTS*32-1:0] port_phyctl,
    output reg [NPORTS*32-1:0] port_tlctl,
    output reg [NPORTS*32-1:0] port_txmgn,
    output reg [NPORTS*32-1:0] port_devcap2,
    output reg load_done
);

    localparam [2:0] ST_START = 3'h0;
    localparam [2:0] ST_REQ = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_APPLY = 3'h3;
    localparam [2:0] ST_DONE = 3'h4;

    reg [2:0] state;
    reg [1:0] word_idx;
    reg [15:0] cap_word;
    reg [15:0] mgn_word;
    reg defaults_used;
    reg force_defaults;
    reg reload_pend;
    reg [1:0] port_sel;
    reg [31:0] rd_mux;
    reg rd_bad;
    reg wr_bad;
    wire wr_en;
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire rd_en;
    wire [7:0] rd_addr;

    // EEPROM address of each word in load order
    function [7:0] word_addr;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: word_addr = `ECLW_EEP_SUBSYS_VID;
                2'h1: word_addr = `ECLW_EEP_SUBSYS_ID;
                2'h2: word_addr = `ECLW_EEP_CAP_CTRL;
                default: word_addr = `ECLW_EEP_TX_MARGIN;
            endcase
        end
    endfunction

    // Picks one port's 32-bit image out of a packed bus
    function [31:0] pick;
        input [NPORTS*32-1:0] bus;
        input [1:0] p;
        integer k;
        begin
            pick = 32'h00000000;
            for (k = 0; k < NPORTS; k = k + 1) begin
                if (p == k[1:0]) begin
                    pick = bus[k*32 +: 32];
                end
            end
        end
    endfunction

    // Register accesses stall until the load has finished
    eclw_axil_slave u_slave (
        .clk_sys(clk_sys),
        .rst(rst),
        .accept(load_done),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_bad),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_mux),
        .rd_err(rd_bad)
    );

    // Load sequencer; a reload request during a load is held over
    always @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_START;
            word_idx <= 2'h0;
            eep_req <= 1'b0;
            eep_addr <= 8'h00;
            load_done <= 1'b0;
            defaults_used <= 1'b0;
            subsys_vendor_id <= `ECLW_DEF_SUBSYS_VID;
            subsys_id <= `ECLW_DEF_SUBSYS_ID;
            cap_word <= `ECLW_DEF_CAP_CTRL;
            mgn_word <= `ECLW_DEF_TX_MARGIN;
        end else begin
            case (state)
                ST_START: begin
                    load_done <= 1'b0;
                    word_idx <= 2'h0;
                    // Without an image the built-in values stay in force
                    if (eep_absent || force_defaults) begin
                        defaults_used <= 1'b1;
                        subsys_vendor_id <= `ECLW_DEF_SUBSYS_VID;
                        subsys_id <= `ECLW_DEF_SUBSYS_ID;
                        cap_word <= `ECLW_DEF_CAP_CTRL;
                        mgn_word <= `ECLW_DEF_TX_MARGIN;
                        state <= ST_APPLY;
                    end else begin
                        defaults_used <= 1'b0;
                        state <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    eep_req <= 1'b1;
                    eep_addr <= word_addr(word_idx);
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (eep_ack) begin
                        eep_req <= 1'b0;
                        case (word_idx)
                            2'h0: subsys_vendor_id <= eep_data;
                            2'h1: subsys_id <= eep_data;
                            2'h2: cap_word <= eep_data;
                            default: mgn_word <= eep_data;
                        endcase
                        if (word_idx == 2'h3) begin
                            state <= ST_APPLY;
                        end else begin
                            word_idx <= word_idx + 2'h1;
                            state <= ST_REQ;
                        end
                    end
                end
                ST_APPLY: begin
                    // Images settle this cycle, so done trails them
                    state <= ST_DONE;
                end
                ST_DONE: begin
                    load_done <= 1'b1;
                    if (reload_pend) begin
                        load_done <= 1'b0;
                        state <= ST_START;
                    end
                end
                default: begin
                    state <= ST_START;
                end
            endcase
        end
    end

    // Per-port field images; unfed bits keep their reset zero
    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp = gp + 1) begin : g_port
            always @(posedge clk_sys) begin
                if (rst) begin
                    port_devcap[gp*32 +: 32] <= 32'h00000000;
                    port_linkcap[gp*32 +: 32] <= 32'h00000000;
                    port_capdis[gp*32 +: 32] <= 32'h00000000;
                    port_phyctl[gp*32 +: 32] <= 32'h00000000;
                    port_tlctl[gp*32 +: 32] <= 32'h00000000;
                    port_txmgn[gp*32 +: 32] <= 32'h00000000;
                    port_devcap2[gp*32 +: 32] <= 32'h00000000;
                end else begin
                    port_devcap[gp*32 + `ECLW_F_MPS +: 2] <=
                        cap_word[`ECLW_CW_MPS +: 2];
                    port_devcap[gp*32 + `ECLW_F_RBER] <=
                        cap_word[`ECLW_CW_RBER];
                    port_linkcap[gp*32 + `ECLW_F_ASPM +: 2] <=
                        cap_word[`ECLW_CW_ASPM +: 2];
                    port_linkcap[gp*32 + `ECLW_F_LBN] <=
                        cap_word[`ECLW_CW_LBN] & LBN_PORT_MASK[gp];
                    port_linkcap[gp*32 + `ECLW_F_SDOWN] <=
                        cap_word[`ECLW_CW_SDOWN];
                    port_capdis[gp*32 + `ECLW_F_MSI_DIS] <=
                        cap_word[`ECLW_CW_MSI_DIS];
                    port_capdis[gp*32 + `ECLW_F_PM_DIS] <=
                        cap_word[`ECLW_CW_PM_DIS];
                    port_phyctl[gp*32 + `ECLW_F_CPAR_DIS] <=
                        cap_word[`ECLW_CW_CPAR_DIS];
                    port_tlctl[gp*32 + `ECLW_F_ORD5] <=
                        cap_word[`ECLW_CW_ORD5];
                    port_tlctl[gp*32 + `ECLW_F_FREEZE] <=
                        cap_word[`ECLW_CW_FREEZE];
                    port_tlctl[gp*32 + `ECLW_F_SOF] <=
                        cap_word[`ECLW_CW_SOF];
                    port_tlctl[gp*32 + `ECLW_F_PMDS] <=
                        cap_word[`ECLW_CW_PMDS];
                    port_tlctl[gp*32 + `ECLW_F_4KB] <=
                        cap_word[`ECLW_CW_4KB];
                    // Three 5-bit margins: low, high de-emphasis, half
                    port_txmgn[gp*32 + `ECLW_F_MGN_LOW +: 5] <=
                        mgn_word[4:0];
                    port_txmgn[gp*32 + `ECLW_F_MGN_HIGH +: 5] <=
                        mgn_word[9:5];
                    port_txmgn[gp*32 + `ECLW_F_MGN_HALF +: 5] <=
                        mgn_word[14:10];
                    port_devcap2[gp*32 + `ECLW_F_LTR] <=
                        cap_word[`ECLW_CW_LTR];
                    port_devcap2[gp*32 + `ECLW_F_OBFF] <=
                        mgn_word[`ECLW_MW_OBFF];
                end
            end
        end
    endgenerate

    // Software controls; a reload only starts from the finished state
    always @(posedge clk_sys) begin
        if (rst) begin
            force_defaults <= 1'b0;
            reload_pend <= 1'b0;
            port_sel <= 2'h0;
        end else begin
            if (state == ST_DONE && reload_pend) begin
                reload_pend <= 1'b0;
            end
            if (wr_en && !wr_bad && wr_strb[0]) begin
                if (wr_addr == `ECLW_REG_CTRL) begin
                    force_defaults <= wr_data[1];
                    if (wr_data[0]) begin
                        reload_pend <= 1'b1;
                    end
                end
                if (wr_addr == `ECLW_REG_PORT_SEL) begin
                    port_sel <= wr_data[1:0];
                end
            end
        end
    end

    // Writes outside the two writable words answer with an error
    always @* begin
        wr_bad = !(wr_addr == `ECLW_REG_CTRL ||
                   wr_addr == `ECLW_REG_PORT_SEL);
    end

    // Read decode; images follow the port chosen in the select word
    always @* begin
        rd_mux = 32'h00000000;
        rd_bad = 1'b0;
        case (rd_addr)
            `ECLW_REG_CTRL: rd_mux = {30'h00000000, force_defaults, 1'b0};
            `ECLW_REG_STATUS: rd_mux = {29'h00000000, defaults_used,
                                        reload_pend, load_done};
            `ECLW_REG_SUBSYS: rd_mux = {subsys_id, subsys_vendor_id};
            `ECLW_REG_WORDS: rd_mux = {mgn_word, cap_word};
            `ECLW_REG_PORT_SEL: rd_mux = {30'h00000000, port_sel};
            `ECLW_REG_DEVCAP: rd_mux = pick(port_devcap, port_sel);
            `ECLW_REG_LINKCAP: rd_mux = pick(port_linkcap, port_sel);
            `ECLW_REG_CAPDIS: rd_mux = pick(port_capdis, port_sel);
            `ECLW_REG_PHYCTL: rd_mux = pick(port_phyctl, port_sel);
            `ECLW_REG_TLCTL: rd_mux = pick(port_tlctl, port_sel);
            `ECLW_REG_TXMGN: rd_mux = pick(port_txmgn, port_sel);
            `ECLW_REG_DEVCAP2: rd_mux = pick(port_devcap2, port_sel);
            default: rd_bad = 1'b1;
        endcase
    end

endmodule
